// ===== logic/tgb_defines.svh
// Constants of the transmit sync gearbox: register map, field positions,
// reset values, header lengths and sequence pause values.
// Assumes it is included by bare name by every file that needs a figure.
`ifndef TGB_DEFINES_SVH
`define TGB_DEFINES_SVH

// Register byte addresses and address width.
`define TGB_ADDR_W        12
`define TGB_ADDR_CFG      12'h000
`define TGB_ADDR_STAT     12'h004

// Configuration register layout and reset value.
`define TGB_CFG_RST       32'h0000_0143
`define TGB_CFG_MASK      32'h0000_03ff
`define TGB_CFG_EN        0
`define TGB_CFG_MODE_LO   1
`define TGB_CFG_MODE_HI   5
`define TGB_CFG_INT_LO    6
`define TGB_CFG_INT_HI    7
`define TGB_CFG_IF_LO     8
`define TGB_CFG_IF_HI     9

// Gearbox mode bit positions.
`define TGB_MODE_66B      0
`define TGB_MODE_RSV1     1
`define TGB_MODE_CAUI     2
`define TGB_MODE_RSV3     3
`define TGB_MODE_ASYNC    4

// Status register layout.
`define TGB_STAT_PAUSE    0
`define TGB_STAT_CFGERR   1
`define TGB_STAT_VALID    2
`define TGB_STAT_BLK_LO   16

// Sync header lengths and payload half width.
`define TGB_HDR66_LEN     9'h002
`define TGB_HDR67_LEN     9'h003
`define TGB_HALF_LEN      9'h040

// Interface widths in bits.
`define TGB_BITS_2B       9'h010
`define TGB_BITS_4B       9'h020
`define TGB_BITS_8B       9'h040
`define TGB_BITS_16B      9'h080

// Sequence values at which the fabric pauses.
`define TGB_P66           7'h20
`define TGB_P66_2B        7'h1f
`define TGB_P67_A         7'h16
`define TGB_P67_B         7'h2c
`define TGB_P67_C         7'h42
`define TGB_P67_2B_A      7'h15
`define TGB_P67_2B_C      7'h41

`endif

// ===== logic/tgb_pkg.sv
// Types shared by the transmit sync gearbox files.
// Assumes tgb_defines.svh sits in the include path.
package tgb_pkg;

   // Width code used for both the fabric interface and the internal path.
   typedef enum logic [1:0] {
      TGB_W2  = 2'b00,
      TGB_W4  = 2'b01,
      TGB_W8  = 2'b10,
      TGB_W16 = 2'b11
   } tgb_width_t;

   // Whole state of the gearbox top module.
   typedef struct packed {
      logic [383:0] acc;
      logic [8:0]   fill;
      logic [1:0]   widx;
      logic [127:0] out_word;
      logic         out_valid;
      logic         pready;
      logic         pslverr;
      logic [31:0]  prdata;
      logic [31:0]  cfg;
      logic [15:0]  blk_cnt;
      logic         pause;
   } tgb_state_t;

endpackage

// ===== logic/tgb_pause_dec.sv
// Decoder of the sequence values at which fabric data is paused.
// Assumes a sequence value that is steady for the whole cycle.
`include "tgb_defines.svh"

module tgb_pause_dec (
   // Sequence and format.
   input  wire logic [6:0] seq,
   input  wire logic       fmt67,
   input  wire logic       int2b,
   // Decoded pause.
   output logic            pause
);

   // Pause values depend on block format and on the 2-byte internal path.
   always_comb begin
      if (!fmt67) begin
         pause = (seq == (int2b ? `TGB_P66_2B : `TGB_P66));
      end else if (int2b) begin
         pause = (seq == `TGB_P67_2B_A) || (seq == `TGB_P67_B) ||
                 (seq == `TGB_P67_2B_C);
      end else begin
         pause = (seq == `TGB_P67_A) || (seq == `TGB_P67_B) ||
                 (seq == `TGB_P67_C);
      end
   end

endmodule

// ===== logic/tgb_gearbox.sv
// Transmit sync gearbox: packs headers and payload into one word per cycle.
// Assumes inputs synchronous to core_clk and an APB master for configuration.
//
// Summary of operation
// - Mode bit0 clear is 67-bit, set 66-bit.
// - One mode setting drives transmit and receive.
// - First 4-byte word: header then 30 bits.
// - Second word: two leftover bits, 30 new.
// - Third word: two bits, next header, 28.
// - Fabric widths of 2, 4, 8, 16 bytes.
// - Header bits 5:3 carry extra header information.
// - Header field sizes per format and width.
// - Data held during pause cycles, then resumes.
// - 66-bit, 8-byte on 4-byte: pause at 32.
// - 66-bit on 2-byte path: pause at 31.
// - 67-bit on 2-byte path: pause 21,44,65.
// - 67-bit on 4-byte path: pause 22,44,66.
// - 67-bit on 8-byte path: same three pauses.
// - 16-byte: upper half block is sent first.
//
// The implementer's own choices: the address map and the APB slave port.
`include "tgb_defines.svh"

module tgb_gearbox #(
   parameter int ACC_W = 384
) (
   // Clock and reset.
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   // APB slave.
   input  wire logic [`TGB_ADDR_W-1:0] paddr,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [31:0]            pwdata,
   output logic                        pready,
   output logic [31:0]                 prdata,
   output logic                        pslverr,
   // Fabric transmit side.
   input  wire logic                   tx_path_reset,
   input  wire logic [6:0]             tx_seq_count_in,
   input  wire logic [127:0]           tx_payload_in,
   input  wire logic [5:0]             tx_sync_header_in,
   // Internal datapath side.
   output logic [127:0]                tx_int_word,
   output logic                        tx_int_valid,
   // Configuration seen by the rest of the transceiver.
   output logic                        gearbox_enable_attr,
   output logic [4:0]                  tx_gearbox_mode,
   output logic [4:0]                  rx_gearbox_mode,
   output tgb_pkg::tgb_width_t         internal_path_width_cfg
);
   import tgb_pkg::*;

   tgb_state_t s;
   tgb_state_t s_nxt;

   logic [4:0]       mode;
   tgb_width_t       int_w;
   tgb_width_t       if_w;
   logic             fmt67;
   logic             gb_on;
   logic             cfg_err;
   logic             pause_w;
   logic             accept;
   logic [8:0]       hl;
   logic [8:0]       wbits;
   logic [1:0]       widx_last;
   logic [127:0]     dm;
   logic [2:0]       hdr_lo;
   logic [2:0]       hdr_hi;
   logic [ACC_W-1:0] chunk;
   logic [8:0]       clen;
   logic [ACC_W-1:0] merged;
   logic [8:0]       tot;
   logic [15:0]      blk_inc;
   logic [31:0]      stat;

   // Configuration decode from the single configuration register.
   assign mode    = s.cfg[`TGB_CFG_MODE_HI:`TGB_CFG_MODE_LO];
   assign int_w   = tgb_width_t'(s.cfg[`TGB_CFG_INT_HI:`TGB_CFG_INT_LO]);
   assign if_w    = tgb_width_t'(s.cfg[`TGB_CFG_IF_HI:`TGB_CFG_IF_LO]);
   assign fmt67   = !mode[`TGB_MODE_66B];
   assign gb_on   = s.cfg[`TGB_CFG_EN] && !mode[`TGB_MODE_ASYNC];
   assign cfg_err = mode[`TGB_MODE_RSV3] || mode[`TGB_MODE_RSV1] ||
                    (mode[`TGB_MODE_ASYNC] && fmt67);

   // Pause decoding of the fabric sequence count.
   tgb_pause_dec u_pause (
      .seq   (tx_seq_count_in),
      .fmt67 (fmt67),
      .int2b (int_w == TGB_W2),
      .pause (pause_w)
   );

   // Status word assembled from live state.
   assign stat = {s.blk_cnt, 13'h0000, s.out_valid, cfg_err, s.pause};

   // Header length, word width and input field selection.
   always_comb begin
      hl = fmt67 ? `TGB_HDR67_LEN : `TGB_HDR66_LEN;
      case (if_w)
         TGB_W2: begin
            wbits     = `TGB_BITS_2B;
            widx_last = 2'h3;
            dm        = {112'h0, tx_payload_in[15:0]};
         end
         TGB_W4: begin
            wbits     = `TGB_BITS_4B;
            widx_last = 2'h1;
            dm        = {96'h0, tx_payload_in[31:0]};
         end
         TGB_W8: begin
            wbits     = `TGB_BITS_8B;
            widx_last = 2'h0;
            dm        = {64'h0, tx_payload_in[63:0]};
         end
         default: begin
            wbits     = `TGB_BITS_16B;
            widx_last = 2'h0;
            dm        = tx_payload_in;
         end
      endcase
      // Unused header bits are ignored whatever the fabric drives.
      hdr_lo = fmt67 ? tx_sync_header_in[2:0] : {1'b0, tx_sync_header_in[1:0]};
      hdr_hi = fmt67 ? tx_sync_header_in[5:3] : {1'b0, tx_sync_header_in[4:3]};
   end

   // Bits appended this cycle, header at the low end so it leaves first.
   always_comb begin
      blk_inc = 16'h0000;
      if (!gb_on) begin
         chunk = ACC_W'(dm);
         clen  = wbits;
      end else if (if_w == TGB_W16) begin
         // Upper half and its header form the block sent first.
         chunk = ACC_W'(hdr_hi) | (ACC_W'(dm[127:64]) << hl) |
                 (ACC_W'(hdr_lo) << (hl + `TGB_HALF_LEN)) |
                 (ACC_W'(dm[63:0]) << (hl + hl + `TGB_HALF_LEN));
         clen    = hl + hl + `TGB_BITS_16B;
         blk_inc = 16'h0002;
      end else if (s.widx == 2'h0) begin
         chunk   = ACC_W'(hdr_lo) | (ACC_W'(dm) << hl);
         clen    = hl + wbits;
         blk_inc = 16'h0001;
      end else begin
         chunk = ACC_W'(dm);
         clen  = wbits;
      end
   end

   // Pause cycles add nothing to the accumulator; a full word waiting in it still drains.
   // The path reset also stops acceptance, so no header is counted while it is held.
   assign accept = !(gb_on && pause_w) && !tx_path_reset;
   assign merged = accept ? (s.acc | (chunk << s.fill)) : s.acc;
   assign tot    = accept ? (s.fill + clen) : s.fill;

   // Next state of datapath and register file.
   always_comb begin
      s_nxt         = s;
      s_nxt.pause   = gb_on && pause_w;
      s_nxt.pready  = 1'b0;
      s_nxt.pslverr = 1'b0;
      // Datapath: emit one full interface word whenever enough bits wait.
      if (tot >= wbits) begin
         s_nxt.out_word  = merged[127:0] & ~({128{1'b1}} << wbits);
         s_nxt.out_valid = 1'b1;
         s_nxt.acc       = merged >> wbits;
         s_nxt.fill      = tot - wbits;
      end else begin
         s_nxt.out_valid = 1'b0;
         s_nxt.acc       = merged;
         s_nxt.fill      = tot;
      end
      if (accept && gb_on) begin
         s_nxt.widx    = (s.widx == widx_last) ? 2'h0 : s.widx + 2'h1;
         s_nxt.blk_cnt = s.blk_cnt + blk_inc;
      end
      // The path reset drops partial blocks so the count restarts aligned.
      if (tx_path_reset) begin
         s_nxt.acc       = '0;
         s_nxt.fill      = 9'h000;
         s_nxt.widx      = 2'h0;
         s_nxt.out_valid = 1'b0;
         s_nxt.out_word  = 128'h0;
      end
      // APB setup cycle prepares the answer for the access cycle.
      if (psel && !penable) begin
         s_nxt.pready = 1'b1;
         case (paddr)
            `TGB_ADDR_CFG:  s_nxt.prdata = s.cfg;
            `TGB_ADDR_STAT: s_nxt.prdata = stat;
            default: begin
               s_nxt.prdata  = 32'h0000_0000;
               s_nxt.pslverr = 1'b1;
            end
         endcase
      end
      // A write takes effect at the completing access edge.
      if (psel && penable && s.pready && pwrite && paddr == `TGB_ADDR_CFG) begin
         s_nxt.cfg = pwdata & `TGB_CFG_MASK;
      end
   end

   // State register.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s     <= '0;
         s.cfg <= `TGB_CFG_RST;
      end else begin
         s <= s_nxt;
      end
   end

   // Outputs come straight from the state register.
   assign pready                  = s.pready;
   assign prdata                  = s.prdata;
   assign pslverr                 = s.pslverr;
   assign tx_int_word             = s.out_word;
   assign tx_int_valid            = s.out_valid;
   assign gearbox_enable_attr     = s.cfg[`TGB_CFG_EN];
   assign tx_gearbox_mode         = mode;
   assign rx_gearbox_mode         = mode;
   assign internal_path_width_cfg = int_w;

   // Checks on the shared mode, packing and pause behaviour.
   a_mode_shared: assert property (@(posedge core_clk) disable iff (!rst_n)
      (tx_gearbox_mode == rx_gearbox_mode) &&
      (rx_gearbox_mode == s.cfg[`TGB_CFG_MODE_HI:`TGB_CFG_MODE_LO]))
      else $error("Transmit and receive gearbox modes differ.");

   a_pause_frozen: assert property (@(posedge core_clk) disable iff (!rst_n)
      (gb_on && pause_w && !tx_path_reset && $stable(s.cfg))
      |=> (s.fill <= $past(s.fill)) && (s.widx == $past(s.widx)))
      else $error("Input was packed during a pause cycle.");

   a_pause_66_4b: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!fmt67 && int_w == TGB_W4 && gb_on) |-> (pause_w == (tx_seq_count_in == `TGB_P66)))
      else $error("66-bit pause not at count 32.");

   a_pause_66_2b: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!fmt67 && int_w == TGB_W2) |-> (pause_w == (tx_seq_count_in == `TGB_P66_2B)))
      else $error("66-bit 2-byte pause not at count 31.");

   a_pause_67_2b: assert property (@(posedge core_clk) disable iff (!rst_n)
      (fmt67 && int_w == TGB_W2) |->
      (pause_w == (tx_seq_count_in inside {`TGB_P67_2B_A, `TGB_P67_B, `TGB_P67_2B_C})))
      else $error("67-bit 2-byte pause at wrong count.");

   a_pause_67_4b: assert property (@(posedge core_clk) disable iff (!rst_n)
      (fmt67 && int_w == TGB_W4) |->
      (pause_w == (tx_seq_count_in inside {`TGB_P67_A, `TGB_P67_B, `TGB_P67_C})))
      else $error("67-bit 4-byte pause at wrong count.");

   a_pause_67_8b: assert property (@(posedge core_clk) disable iff (!rst_n)
      (fmt67 && int_w == TGB_W8 && tx_seq_count_in inside {7'h17, 7'h2d}) |-> !pause_w)
      else $error("67-bit 8-byte data not resumed after pause.");

   a_first_word: assert property (@(posedge core_clk) disable iff (!rst_n)
      (gb_on && !fmt67 && if_w == TGB_W4 && accept && s.widx == 2'h0 && s.fill == 9'h000 &&
       !tx_path_reset)
      |=> tx_int_valid && tx_int_word[31:0] == {$past(tx_payload_in[29:0]),
                                                 $past(tx_sync_header_in[1:0])})
      else $error("First word is not header plus 30 data bits.");

   a_third_word: assert property (@(posedge core_clk) disable iff (!rst_n)
      (gb_on && !fmt67 && if_w == TGB_W4 && accept && s.widx == 2'h0 && s.fill == 9'h000 &&
       !tx_path_reset && $stable(s.cfg))
      ##1 (accept && !tx_path_reset && $stable(s.cfg))
      ##1 (accept && !tx_path_reset && $stable(s.cfg))
      |=> tx_int_word[31:0] == {$past(tx_payload_in[27:0]), $past(tx_sync_header_in[1:0]),
                                $past(tx_payload_in[31:30], 2)})
      else $error("Third word does not join two blocks correctly.");

   a_upper_first: assert property (@(posedge core_clk) disable iff (!rst_n)
      (gb_on && !fmt67 && if_w == TGB_W16 && accept && s.fill == 9'h000 && !tx_path_reset)
      |=> tx_int_word[65:0] == {$past(tx_payload_in[127:64]), $past(tx_sync_header_in[4:3])})
      else $error("Upper half block was not sent first.");

   // A held path reset leaves no partial block behind.
   a_reset_flush: assert property (@(posedge core_clk) disable iff (!rst_n)
      tx_path_reset |=> !tx_int_valid && (s.fill == 9'h000) && (s.widx == 2'h0))
      else $error("Path reset did not flush the accumulator.");

   // Each accepted 16-byte beat carries exactly two blocks.
   a_blk_count: assert property (@(posedge core_clk) disable iff (!rst_n)
      (gb_on && accept && if_w == TGB_W16) |=> (s.blk_cnt == $past(s.blk_cnt) + 16'h0002))
      else $error("Block counter did not count two blocks.");

   // The bus answer stands for one cycle only.
   a_ready_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
      pready |=> !pready)
      else $error("Ready stood longer than one cycle.");

   // An error response only comes with ready.
   a_err_ready: assert property (@(posedge core_clk) disable iff (!rst_n)
      pslverr |-> pready)
      else $error("Error response without ready.");

endmodule

// ===== testbench/tgb_fabric_model.sv
// Fabric model: drives sequence count, payload and headers into the gearbox.
// Assumes the bench sets format and widths before raising run.
module tgb_fabric_model (
   // Clock and control.
   input  wire logic    core_clk,
   input  wire logic    run,
   input  wire logic    fmt67,
   input  wire logic [1:0] int_w,
   input  wire logic [1:0] if_w,
   // Stream into the gearbox.
   output logic         tx_path_reset,
   output logic [6:0]   tx_seq_count_in,
   output logic [127:0] tx_payload_in,
   output logic [5:0]   tx_sync_header_in,
   // Beat offered this cycle and end of run.
   output logic         take,
   output logic         done
);
   timeunit 1ns;
   timeprecision 100ps;
   int          c;
   int          s;
   int          k;
   int          b;
   logic [31:0] p;

   // Header of block n, a legal sync pattern.
   function automatic logic [2:0] hdr(input int n, input logic f);
      hdr = {f & n[1], n[0] ? 2'b10 : 2'b01};
   endfunction

   // Pause counts of the format and internal width.
   function automatic logic pause(input int n);
      if (fmt67) begin
         pause = (n == 44) || (n == ((int_w == 2'b00) ? 21 : 22))
                 || (n == ((int_w == 2'b00) ? 65 : 66));
      end else begin
         pause = n == ((int_w == 2'b00) ? 31 : 32);
      end
   endfunction

   // Idle state: path held in reset with count zero.
   initial begin
      tx_path_reset = 1'b1;
      tx_seq_count_in = 7'h00;
      tx_payload_in = '0;
      tx_sync_header_in = 6'h00;
      take = 1'b0;
      done = 1'b0;
   end

   // One full turn of the count; data and header held over pauses.
   always begin
      @(posedge core_clk iff run);
      k = 0;
      for (c = 0; c <= (fmt67 ? 66 : 32); c++) begin
         for (s = 0; s < ((if_w == int_w) ? 2 : 1); s++) begin
            tx_seq_count_in <= 7'(c);
            tx_path_reset <= 1'b0;
            take <= !pause(c);
            if (!pause(c)) begin
               b = (if_w == 2'b11) ? 2 * k : (k >> (2 - int'(if_w)));
               p = 32'(k) * 32'h9e37_79b1;
               tx_payload_in <= {~p, p ^ 32'h0ff0_a55a, p + 32'h1, p}
                                & ({128{1'b1}} >> (128 - (16 << if_w)));
               tx_sync_header_in <= (if_w == 2'b11) ? {hdr(b, fmt67), hdr(b + 1, fmt67)}
                                    : {3'b000, hdr(b, fmt67)};
               k++;
            end
            @(posedge core_clk);
         end
      end
      tx_path_reset <= 1'b1;
      tx_seq_count_in <= 7'h00;
      take <= 1'b0;
      done <= 1'b1;
      @(posedge core_clk iff !run);
      done <= 1'b0;
   end
endmodule

// ===== testbench/tb_top.sv
// Bench of the transmit gearbox: APB setup, fabric model, bit-queue scoreboard.
// Assumes tgb_defines.svh in the include path and registered design outputs.
`include "tgb_defines.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import tgb_pkg::*;
   logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, tx_path_reset;
   logic fab_run, fab_take, fab_done, cfg_f67, tx_int_valid, gearbox_enable_attr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [6:0] tx_seq_count_in;
   logic [127:0] tx_payload_in, tx_int_word;
   logic [5:0] tx_sync_header_in;
   logic [4:0] tx_gearbox_mode, rx_gearbox_mode;
   logic [1:0] cfg_iw, cfg_fw;
   tgb_width_t int_width_out;
   logic exp_q[$];
   int mismatches, n_checks, cycles, bits, hl, wi;

   tgb_gearbox u_tgb_gearbox (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .tx_path_reset(tx_path_reset), .tx_seq_count_in(tx_seq_count_in),
      .tx_payload_in(tx_payload_in), .tx_sync_header_in(tx_sync_header_in),
      .tx_int_word(tx_int_word), .tx_int_valid(tx_int_valid),
      .gearbox_enable_attr(gearbox_enable_attr), .tx_gearbox_mode(tx_gearbox_mode),
      .rx_gearbox_mode(rx_gearbox_mode), .internal_path_width_cfg(int_width_out));
   tgb_fabric_model u_tgb_fabric_model (.core_clk(core_clk), .run(fab_run), .fmt67(cfg_f67),
      .int_w(cfg_iw), .if_w(cfg_fw), .tx_path_reset(tx_path_reset),
      .tx_seq_count_in(tx_seq_count_in), .tx_payload_in(tx_payload_in),
      .tx_sync_header_in(tx_sync_header_in), .take(fab_take), .done(fab_done));

   task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic push(input int n, input logic [127:0] v);
      for (int i = 0; i < n; i++) exp_q.push_back(v[i]);
   endtask

   // APB master: setup, then access held until pready is sampled high.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   // Reset values and a refused write to an unmapped place.
   task automatic test_regs();
      logic [31:0] rd;
      logic err;
      apb(1'b0, `TGB_ADDR_CFG, 32'h0, rd, err);
      check("cfg_reset", 128'(rd), 128'(`TGB_CFG_RST));
      check("mode_pair", 128'({tx_gearbox_mode, rx_gearbox_mode}), 128'(10'h021));
      check("enable_attr", 128'(gearbox_enable_attr), 128'(1'b1));
      apb(1'b0, `TGB_ADDR_STAT, 32'h0, rd, err);
      check("stat_idle", 128'(rd), 128'(32'h0000_0000));
      apb(1'b1, 12'h008, 32'h0000_0000, rd, err);
      check("unmapped_err", 128'(err), 128'(1'b1));
      apb(1'b0, `TGB_ADDR_CFG, 32'h0, rd, err);
      check("cfg_kept", 128'(rd), 128'(`TGB_CFG_RST));
   endtask

   // One full count turn in a given format and width pair.
   task automatic test_stream(input logic f67, input logic [1:0] iw, input logic [1:0] fw);
      logic [31:0] rd;
      logic err;
      int n;
      apb(1'b1, `TGB_ADDR_CFG, {22'h0, fw, iw, 4'h0, ~f67, 1'b1}, rd, err);
      check("mode_pair", 128'({tx_gearbox_mode, rx_gearbox_mode}), 128'({2{4'h0, ~f67}}));
      check("int_width", 128'(int_width_out), 128'(iw));
      cfg_f67 <= f67;
      cfg_iw <= iw;
      cfg_fw <= fw;
      exp_q.delete();
      wi = 0;
      bits = 16 << fw;
      hl = f67 ? 3 : 2;
      fab_run <= 1'b1;
      n = 0;
      while (fab_done !== 1'b1 && n < 400) begin
         @(posedge core_clk);
         n++;
      end
      check("run_done", 128'(fab_done), 128'(1'b1));
      fab_run <= 1'b0;
      repeat (4) @(posedge core_clk);
      check("leftover_bits", 128'(exp_q.size()), 128'(0));
   endtask

   // Scoreboard: expected bit stream, header first and LSB first.
   always @(posedge core_clk) begin
      logic [127:0] w;
      w = '0;
      if (tx_int_valid === 1'b1 && exp_q.size() < bits) begin
         check("word_count", 128'(exp_q.size()), 128'(bits));
      end else if (tx_int_valid === 1'b1) begin
         for (int i = 0; i < bits; i++) w[i] = exp_q.pop_front();
         check("tx_int_word", tx_int_word, w);
      end
      if (fab_take === 1'b1 && bits == 128) begin
         push(hl, 128'(tx_sync_header_in[5:3]));
         push(64, 128'(tx_payload_in[127:64]));
         push(hl, 128'(tx_sync_header_in[2:0]));
         push(64, 128'(tx_payload_in[63:0]));
      end else if (fab_take === 1'b1) begin
         if (wi == 0) push(hl, 128'(tx_sync_header_in[2:0]));
         push(bits, tx_payload_in);
         wi = (wi + 1) % (64 / bits);
      end
   end

   // Clock at 40 MHz.
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // Hang guard.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict();
      end
   end

   // Main sequence.
   initial begin
      {rst_n, psel, penable, pwrite, fab_run, cfg_f67} = 6'h00;
      {paddr, pwdata} = '0;
      {cfg_iw, cfg_fw} = 4'h5;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      test_regs();
      test_stream(1'b0, 2'b01, 2'b01);
      test_stream(1'b1, 2'b01, 2'b01);
      test_stream(1'b0, 2'b01, 2'b10);
      test_stream(1'b0, 2'b00, 2'b00);
      test_stream(1'b1, 2'b00, 2'b00);
      test_stream(1'b1, 2'b10, 2'b11);
      print_verdict();
   end
endmodule
